// *** timer_consts.vh ***
/*
 holds: offsets, fields, reset values, mode codes and TOP values.
 assumes: included by bare name by every design file of the timer except the waveform channel.
*/
// What this block does
// (RULE1) one clock; the timer tick is a one-cycle enable.
// (RULE2) frequency-correct modes load compares at BOTTOM.
// (RULE3) control A output modes: A 7:6, B 5:4, C 3:2.
// (RULE4) nonzero output mode gives the pin to the waveform; code hands it over for 01 only where 01 toggles.
// (RULE5) software sets the pin direction bit to enable the driver.
// (RULE6) non-PWM: 00 off, 01 toggle, 10 clear, 11 set on match.
// (RULE7) fast PWM: 10 clear on match, set at BOTTOM; 11 inverse.
// (RULE8) fast PWM 01 toggles channel A only in mode 15.
// (RULE9) fast PWM compare at TOP with upper bit set: match ignored.
// (RULE10) phase-correct: 10 clear up-match, set down-match; 11 inverse.
// (RULE11) phase-correct 01 toggles channel A only in modes 9, 11.
// (RULE12) wave mode: control A 1:0 plus two control B bits.
// (RULE13) modes 1-3 dual slope, fixed TOP, load TOP, overflow BOTTOM.
// (RULE14) modes 8/9 load and overflow at BOTTOM.
// (RULE15) modes 10/11 dual slope register TOP; mode 0 counts to 0xFFFF.
// (RULE16) modes 4/12 clear on match, immediate update; 13 reserved.
// (RULE17) modes 5-7, 14, 15 fast PWM, load BOTTOM, overflow TOP.
// (RULE18) BOTTOM overflow keeps the TOP cycle relation.
// (RULE19) control A is read/write, resets to zero.
// (RULE20) tick select: stop, /1 to /1024, external edges.
// (RULE21) reserved mode 13: pins off, counter held at zero.
// (RULE22) outputs and flags act on the matching tick.
`ifndef TIMER_CONSTS_VH
`define TIMER_CONSTS_VH

// ================
// register offsets
`define OFS_CTRL_A 4'h0
`define OFS_CTRL_B 4'h1
`define OFS_COUNT 4'h2
`define OFS_CMP_A 4'h3
`define OFS_CMP_B 4'h4
`define OFS_CMP_C 4'h5
`define OFS_CAPTURE 4'h6
`define OFS_STATUS 4'h7

// ================
// field positions
`define CTRLA_OM_A 7:6
`define CTRLA_OM_B 5:4
`define CTRLA_OM_C 3:2
`define CTRLA_WM_LOW 1:0
`define CTRLB_WM_HIGH 4:3
`define CTRLB_TICK_SEL 2:0
`define STAT_OVF 0
`define STAT_MATCH_A 1

// ================
// reset values
`define CTRL_A_RST 8'h00
`define CTRL_B_RST 8'h00
`define WORD_RST 16'h0000

// ================
// mode codes and fixed TOP values
`define WM_NORMAL 4'h0
`define WM_PC8 4'h1
`define WM_PC9 4'h2
`define WM_PC10 4'h3
`define WM_CTC_CMP 4'h4
`define WM_FAST8 4'h5
`define WM_FAST9 4'h6
`define WM_FAST10 4'h7
`define WM_PFC_CAP 4'h8
`define WM_PFC_CMP 4'h9
`define WM_PC_CAP 4'ha
`define WM_PC_CMP 4'hb
`define WM_CTC_CAP 4'hc
`define WM_RESERVED 4'hd
`define WM_FAST_CAP 4'he
`define WM_FAST_CMP 4'hf
`define TOP_8BIT 16'h00ff
`define TOP_9BIT 16'h01ff
`define TOP_10BIT 16'h03ff
`define TOP_MAX 16'hffff

// ================
// tick select codes and prescaler terminal counts
`define TS_STOP 3'h0
`define TS_DIV1 3'h1
`define TS_DIV8 3'h2
`define TS_DIV64 3'h3
`define TS_DIV256 3'h4
`define TS_DIV1024 3'h5
`define TS_EXT_FALL 3'h6
`define TS_EXT_RISE 3'h7
`define DIV8_END 10'h007
`define DIV64_END 10'h03f
`define DIV256_END 10'h0ff
`define DIV1024_END 10'h3ff

`endif

// *** tick_gen.v ***
/*
 holds: the prescaler that turns core_clk into the one-cycle timer tick.
 assumes: ext_pin_s is already synchronised to core_clk.
*/
`timescale 1ns/100ps
`include "timer_consts.vh"

module tick_gen (
   input wire core_clk,
   input wire rstn,
   input wire [2:0] tick_select,
   input wire ext_pin_s,
   output reg tick_q
);

   reg [9:0] div_q;
   reg pin_prev_q;
   reg tick_d;

   // ================
   // free-running divider and edge memory
   always @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         div_q <= 10'h000;
         pin_prev_q <= 1'b0;
         tick_q <= 1'b0;
      end else begin
         div_q <= div_q + 10'h001;
         pin_prev_q <= ext_pin_s;
         tick_q <= tick_d; // a pulse, never a clock [RULE1]
      end
   end

   // ================
   // tick source select; prescaler runs even when stopped
   always @* begin
      case (tick_select) // [RULE20]
         `TS_DIV1: tick_d = 1'b1;
         `TS_DIV8: tick_d = (div_q[2:0] == `DIV8_END);
         `TS_DIV64: tick_d = (div_q[5:0] == `DIV64_END);
         `TS_DIV256: tick_d = (div_q[7:0] == `DIV256_END);
         `TS_DIV1024: tick_d = (div_q == `DIV1024_END);
         `TS_EXT_FALL: tick_d = pin_prev_q & ~ext_pin_s;
         `TS_EXT_RISE: tick_d = ~pin_prev_q & ext_pin_s;
         default: tick_d = 1'b0;
      endcase
   end

endmodule

// *** wave_channel.v ***
/*
 holds: one compare-output waveform flip-flop.
 assumes: match, bottom_ev and tog_ok are already qualified by the parent.
*/
`timescale 1ns/100ps

module wave_channel (
   input wire core_clk,
   input wire rstn,
   input wire tick,
   input wire fam_non,
   input wire fam_fast,
   input wire fam_dual,
   input wire [1:0] out_mode,
   input wire match,
   input wire bottom_ev,
   input wire up,
   input wire tog_ok,
   output reg wave_q
);

   // ================
   // waveform update, only on a timer tick
   always @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         wave_q <= 1'b0;
      end else if (tick) begin
         if (fam_non && match) begin
            case (out_mode) // [RULE6]
               2'h1: wave_q <= ~wave_q;
               2'h2: wave_q <= 1'b0;
               2'h3: wave_q <= 1'b1;
               default: wave_q <= wave_q;
            endcase
         end else if (fam_fast) begin
            if (out_mode == 2'h1 && tog_ok && match) begin
               wave_q <= ~wave_q; // [RULE8]
            end else if (out_mode[1] && match) begin
               wave_q <= out_mode[0]; // [RULE7]
            end else if (out_mode[1] && bottom_ev) begin
               wave_q <= ~out_mode[0]; // [RULE7]
            end
         end else if (fam_dual && match) begin
            if (out_mode == 2'h1 && tog_ok) begin
               wave_q <= ~wave_q; // [RULE11]
            end else if (out_mode[1]) begin
               wave_q <= up ? out_mode[0] : ~out_mode[0]; // [RULE10]
            end
         end
      end
   end

endmodule

// *** timer16_waveform_mode_control.v ***
/*
 holds: the 16-bit timer with mode decode, counter, compare buffers,
 flags and three compare output pins, plus its register port.
 assumes: one master drives one-cycle strobes on core_clk; ext_pin is
 asynchronous; the port logic outside muxes pins using wave_en_x.
*/
// Strobed register access and the placing of the registers were chosen for this implementation.
`timescale 1ns/100ps
`include "timer_consts.vh"

module timer16_waveform_mode_control (
   input wire core_clk,
   input wire rstn,
   input wire [3:0] reg_addr,
   input wire [15:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   output reg [15:0] reg_rdata,
   input wire ext_pin,
   output wire wave_out_a,
   output wire wave_out_b,
   output wire wave_out_c,
   output reg wave_en_a,
   output reg wave_en_b,
   output reg wave_en_c
);

   // ================
   // register state
   reg [7:0] timer1_control_a_q;
   reg [7:0] timer_control_b_q;
   reg [15:0] count_value_q;
   reg [15:0] capture_value_q;
   reg [15:0] cmp_buf_q [0:2];
   reg [15:0] cmp_act_q [0:2];
   reg overflow_flag_q;
   reg [2:0] match_flag_q;
   reg dir_up_q;
   reg block_q;
   reg pin_meta_q;
   reg pin_sync_q;

   wire tick;
   wire [2:0] wave_bus;
   wire [3:0] wave_mode;
   wire [1:0] out_mode [0:2];
   reg [15:0] top_val;
   reg fam_non;
   reg fam_fast;
   reg fam_dual;
   reg fam_pfc;
   reg fam_rsv;
   wire at_top;
   wire at_bottom;
   wire at_max;
   wire wr_ctrl_a;
   wire wr_ctrl_b;
   wire wr_count;
   wire wr_cap;
   wire wr_stat;
   wire load_ev;
   wire ovf_ev;
   wire [2:0] match_raw;
   wire [2:0] match_eff;
   wire [2:0] tog_ok;
   wire [2:0] en_d;

   // ================
   // control register fields
   assign wave_mode = {timer_control_b_q[`CTRLB_WM_HIGH],
      timer1_control_a_q[`CTRLA_WM_LOW]}; // [RULE12]
   assign out_mode[0] = timer1_control_a_q[`CTRLA_OM_A]; // [RULE3]
   assign out_mode[1] = timer1_control_a_q[`CTRLA_OM_B]; // [RULE3]
   assign out_mode[2] = timer1_control_a_q[`CTRLA_OM_C]; // [RULE3]

   // ================
   // write decode
   assign wr_ctrl_a = reg_wr && (reg_addr == `OFS_CTRL_A);
   assign wr_ctrl_b = reg_wr && (reg_addr == `OFS_CTRL_B);
   assign wr_count = reg_wr && (reg_addr == `OFS_COUNT);
   assign wr_cap = reg_wr && (reg_addr == `OFS_CAPTURE);
   assign wr_stat = reg_wr && (reg_addr == `OFS_STATUS);

   // ================
   // external tick pin synchroniser; only stage two is read
   always @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         pin_meta_q <= 1'b0;
         pin_sync_q <= 1'b0;
      end else begin
         pin_meta_q <= ext_pin;
         pin_sync_q <= pin_meta_q;
      end
   end

   tick_gen u_tick (
      .core_clk(core_clk),
      .rstn(rstn),
      .tick_select(timer_control_b_q[`CTRLB_TICK_SEL]),
      .ext_pin_s(pin_sync_q),
      .tick_q(tick)
   );

   // ================
   // mode decode: family and TOP source
   always @* begin
      top_val = `TOP_MAX;
      fam_non = 1'b0;
      fam_fast = 1'b0;
      fam_dual = 1'b0;
      fam_pfc = 1'b0;
      fam_rsv = 1'b0;
      case (wave_mode)
         `WM_NORMAL: begin
            fam_non = 1'b1; // [RULE15]
         end
         `WM_PC8: begin
            fam_dual = 1'b1;
            top_val = `TOP_8BIT; // [RULE13]
         end
         `WM_PC9: begin
            fam_dual = 1'b1;
            top_val = `TOP_9BIT; // [RULE13]
         end
         `WM_PC10: begin
            fam_dual = 1'b1;
            top_val = `TOP_10BIT; // [RULE13]
         end
         `WM_CTC_CMP: begin
            fam_non = 1'b1;
            top_val = cmp_act_q[0]; // [RULE16]
         end
         `WM_FAST8: begin
            fam_fast = 1'b1;
            top_val = `TOP_8BIT; // [RULE17]
         end
         `WM_FAST9: begin
            fam_fast = 1'b1;
            top_val = `TOP_9BIT; // [RULE17]
         end
         `WM_FAST10: begin
            fam_fast = 1'b1;
            top_val = `TOP_10BIT; // [RULE17]
         end
         `WM_PFC_CAP: begin
            fam_dual = 1'b1;
            fam_pfc = 1'b1;
            top_val = capture_value_q; // [RULE14]
         end
         `WM_PFC_CMP: begin
            fam_dual = 1'b1;
            fam_pfc = 1'b1;
            top_val = cmp_act_q[0]; // [RULE14]
         end
         `WM_PC_CAP: begin
            fam_dual = 1'b1;
            top_val = capture_value_q; // [RULE15]
         end
         `WM_PC_CMP: begin
            fam_dual = 1'b1;
            top_val = cmp_act_q[0]; // [RULE15]
         end
         `WM_CTC_CAP: begin
            fam_non = 1'b1;
            top_val = capture_value_q; // [RULE16]
         end
         `WM_FAST_CAP: begin
            fam_fast = 1'b1;
            top_val = capture_value_q; // [RULE17]
         end
         `WM_FAST_CMP: begin
            fam_fast = 1'b1;
            top_val = cmp_act_q[0]; // [RULE17]
         end
         default: begin
            fam_rsv = 1'b1; // [RULE21]
         end
      endcase
   end

   // ================
   // counter position events
   assign at_top = (count_value_q == top_val);
   assign at_bottom = (count_value_q == `WORD_RST);
   assign at_max = (count_value_q == `TOP_MAX);

   // buffered load: fast at the wrap, phase-correct at TOP,
   // frequency-correct at BOTTOM; immediate modes bypass it
   assign load_ev = tick && ((fam_fast && at_top) ||
      (fam_dual && !fam_pfc && at_top) ||
      (fam_pfc && at_bottom)); // [RULE2] [RULE13] [RULE17]

   // overflow: MAX for non-PWM, TOP for fast, BOTTOM for dual slope;
   // BOTTOM is sampled on the same tick edge as TOP would be
   assign ovf_ev = tick && ((fam_non && at_max) ||
      (fam_fast && at_top) ||
      (fam_dual && at_bottom)); // [RULE16] [RULE17] [RULE18]

   // ================
   // counter and slope direction
   always @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         count_value_q <= `WORD_RST;
         dir_up_q <= 1'b1;
      end else if (wr_count) begin
         count_value_q <= reg_wdata;
      end else if (fam_rsv) begin
         count_value_q <= `WORD_RST; // held, nothing toggles [RULE21]
         dir_up_q <= 1'b1;
      end else if (tick) begin
         if (fam_dual) begin
            if (at_top && dir_up_q) begin
               dir_up_q <= 1'b0;
               count_value_q <= count_value_q - 16'h0001;
            end else if (at_bottom && !dir_up_q) begin
               dir_up_q <= 1'b1;
               count_value_q <= count_value_q + 16'h0001;
            end else if (dir_up_q) begin
               count_value_q <= count_value_q + 16'h0001;
            end else begin
               count_value_q <= count_value_q - 16'h0001;
            end
         end else if ((fam_fast || wave_mode == `WM_CTC_CMP ||
               wave_mode == `WM_CTC_CAP) && at_top) begin
            count_value_q <= `WORD_RST; // [RULE16] [RULE17]
            dir_up_q <= 1'b1;
         end else begin
            count_value_q <= count_value_q + 16'h0001; // wraps at MAX
            dir_up_q <= 1'b1;
         end
      end
   end

   // ================
   // a software count write blocks matches on the next tick
   always @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         block_q <= 1'b0;
      end else if (wr_count) begin
         block_q <= 1'b1;
      end else if (tick) begin
         block_q <= 1'b0;
      end
   end

   // ================
   // control and capture registers
   always @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         timer1_control_a_q <= `CTRL_A_RST; // [RULE19]
         timer_control_b_q <= `CTRL_B_RST;
         capture_value_q <= `WORD_RST;
      end else begin
         if (wr_ctrl_a) begin
            timer1_control_a_q <= reg_wdata[7:0]; // [RULE19]
         end
         if (wr_ctrl_b) begin
            timer_control_b_q <= {3'h0, reg_wdata[4:0]};
         end
         if (wr_cap) begin
            capture_value_q <= reg_wdata;
         end
      end
   end

   // ================
   // per-channel compare buffers, matches and pin ownership
   genvar ch;
   generate
      for (ch = 0; ch < 3; ch = ch + 1) begin : g_ch
         wire wr_cmp;
         assign wr_cmp = reg_wr && (reg_addr == `OFS_CMP_A + ch[3:0]);

         always @(posedge core_clk or negedge rstn) begin
            if (!rstn) begin
               cmp_buf_q[ch] <= `WORD_RST;
               cmp_act_q[ch] <= `WORD_RST;
            end else begin
               if (wr_cmp) begin
                  cmp_buf_q[ch] <= reg_wdata;
               end
               if (fam_non || fam_rsv) begin
                  cmp_act_q[ch] <= wr_cmp ? reg_wdata : cmp_buf_q[ch]; // [RULE16]
               end else if (load_ev) begin
                  cmp_act_q[ch] <= cmp_buf_q[ch]; // [RULE2]
               end
            end
         end

         // equality on the tick itself, unless a count write or the reserved mode blocks it
         assign match_raw[ch] = tick && !block_q && !fam_rsv &&
            (count_value_q == cmp_act_q[ch]); // [RULE22]
         // fast PWM clear/set output modes with compare at TOP: only the BOTTOM action runs
         assign match_eff[ch] = match_raw[ch] && !(fam_fast &&
            out_mode[ch][1] && cmp_act_q[ch] == top_val); // [RULE9]

         if (ch == 0) begin : g_tog
            assign tog_ok[ch] = (fam_fast && wave_mode == `WM_FAST_CMP) ||
               (fam_dual && (wave_mode == `WM_PFC_CMP ||
               wave_mode == `WM_PC_CMP)); // [RULE8] [RULE11]
         end else begin : g_notog
            assign tog_ok[ch] = 1'b0; // [RULE8] [RULE11]
         end

         // pin is handed over only for a mode that really drives it
         assign en_d[ch] = !fam_rsv && out_mode[ch] != 2'h0 &&
            (fam_non || out_mode[ch][1] || tog_ok[ch]); // [RULE4] [RULE21]

         wave_channel u_wave (
            .core_clk(core_clk),
            .rstn(rstn),
            .tick(tick),
            .fam_non(fam_non),
            .fam_fast(fam_fast),
            .fam_dual(fam_dual),
            .out_mode(out_mode[ch]),
            .match(match_eff[ch]),
            .bottom_ev(at_top),
            .up(dir_up_q),
            .tog_ok(tog_ok[ch]),
            .wave_q(wave_bus[ch])
         );
      end
   endgenerate

   assign wave_out_a = wave_bus[0];
   assign wave_out_b = wave_bus[1];
   assign wave_out_c = wave_bus[2];

   // ================
   // pin ownership; direction bit is software's job outside [RULE5]
   always @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         wave_en_a <= 1'b0;
         wave_en_b <= 1'b0;
         wave_en_c <= 1'b0;
      end else begin
         wave_en_a <= en_d[0]; // [RULE4]
         wave_en_b <= en_d[1]; // [RULE4]
         wave_en_c <= en_d[2]; // [RULE4]
      end
   end

   // ================
   // sticky flags, write one to clear; a same-cycle event wins
   always @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         overflow_flag_q <= 1'b0;
         match_flag_q <= 3'h0;
      end else begin
         overflow_flag_q <= ovf_ev |
            (overflow_flag_q & ~(wr_stat & reg_wdata[`STAT_OVF])); // [RULE18]
         match_flag_q <= match_raw |
            (match_flag_q & ~({3{wr_stat}} & reg_wdata[3:1])); // [RULE22]
      end
   end

   // ================
   // read port; data valid the cycle after the strobe only
   always @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         reg_rdata <= `WORD_RST;
      end else if (!reg_rd) begin
         reg_rdata <= `WORD_RST;
      end else begin
         case (reg_addr)
            `OFS_CTRL_A: reg_rdata <= {8'h00, timer1_control_a_q}; // [RULE19]
            `OFS_CTRL_B: reg_rdata <= {8'h00, timer_control_b_q};
            `OFS_COUNT: reg_rdata <= count_value_q;
            `OFS_CMP_A: reg_rdata <= cmp_buf_q[0];
            `OFS_CMP_B: reg_rdata <= cmp_buf_q[1];
            `OFS_CMP_C: reg_rdata <= cmp_buf_q[2];
            `OFS_CAPTURE: reg_rdata <= capture_value_q;
            `OFS_STATUS: reg_rdata <= {12'h000, match_flag_q, overflow_flag_q};
            default: reg_rdata <= `WORD_RST;
         endcase
      end
   end

endmodule

// *** timer16_wave_chk.sv ***
/* checker: port-level behaviour of the waveform timer.
   assumes: bound to the timer top, one clock, rstn resets all. */
`timescale 1ns/100ps
module timer16_wave_chk (
   input wire core_clk,
   input wire rstn,
   input wire [3:0] reg_addr,
   input wire [15:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   input wire [15:0] reg_rdata,
   input wire ext_pin,
   input wire wave_out_a,
   input wire wave_out_b,
   input wire wave_out_c,
   input wire wave_en_a,
   input wire wave_en_b,
   input wire wave_en_c
);
   reg [7:0] ca_q;
   reg [7:0] cb_q;
   reg [2:0] stop_q;
   wire [3:0] wm = {cb_q[4:3], ca_q[1:0]};
   // ================
   // shadow controls; idle count while tick is off, so the tick pipe has drained
   always @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         ca_q <= 8'h00;
         cb_q <= 8'h00;
         stop_q <= 3'h0;
      end else begin
         if (reg_wr && reg_addr == 4'h0)
            ca_q <= reg_wdata[7:0];
         if (reg_wr && reg_addr == 4'h1)
            cb_q <= reg_wdata[7:0];
         if (reg_wr || cb_q[2:0] != 3'h0)
            stop_q <= 3'h0;
         else if (stop_q != 3'h7)
            stop_q <= stop_q + 3'h1;
      end
   end
   // pin ownership expected from mode and output-mode field
   function automatic logic en_fn(input logic [3:0] m, input logic [1:0] om, input logic ch_a);
      logic tog;
      tog = ch_a && om == 2'h1 && (m == 4'hf || m == 4'h9 || m == 4'hb);
      if (m == 4'hd)
         en_fn = 1'b0;
      else if (m == 4'h0 || m == 4'h4 || m == 4'hc)
         en_fn = (om != 2'h0);
      else
         en_fn = om[1] || tog;
   endfunction
   // ================
   // assertions
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rstn);
   property p_rd_idle;
      !reg_rd |=> reg_rdata == 16'h0000;
   endproperty
   a_rd_idle: assert property (p_rd_idle)
      else $error("read data not zero outside a read");
   property p_unmapped;
      reg_rd && reg_addr[3] |=> reg_rdata == 16'h0000;
   endproperty
   a_unmapped: assert property (p_unmapped)
      else $error("unmapped read not zero");
   property p_rd_ctla;
      reg_rd && reg_addr == 4'h0 |=> reg_rdata == {8'h00, $past(ca_q)};
   endproperty
   a_rd_ctla: assert property (p_rd_ctla)
      else $error("control A read back wrong");
   property p_rd_ctlb;
      reg_rd && reg_addr == 4'h1 |=> reg_rdata == {11'h000, $past(cb_q[4:0])};
   endproperty
   a_rd_ctlb: assert property (p_rd_ctlb)
      else $error("control B read back wrong");
   property p_en_a;
      $stable(ca_q) && $stable(cb_q) |-> wave_en_a == en_fn(wm, ca_q[7:6], 1'b1);
   endproperty
   a_en_a: assert property (p_en_a)
      else $error("pin a ownership wrong");
   property p_en_b;
      $stable(ca_q) && $stable(cb_q) |-> wave_en_b == en_fn(wm, ca_q[5:4], 1'b0);
   endproperty
   a_en_b: assert property (p_en_b)
      else $error("pin b ownership wrong");
   property p_en_c;
      $stable(ca_q) && $stable(cb_q) |-> wave_en_c == en_fn(wm, ca_q[3:2], 1'b0);
   endproperty
   a_en_c: assert property (p_en_c)
      else $error("pin c ownership wrong");
   property p_stop_cnt;
      (stop_q == 3'h7 && reg_rd && reg_addr == 4'h2) ##1 (reg_rd && reg_addr == 4'h2)
         |=> reg_rdata == $past(reg_rdata);
   endproperty
   a_stop_cnt: assert property (p_stop_cnt)
      else $error("count moved with tick stopped");
   property p_stop_hold;
      stop_q == 3'h7 |-> $stable(wave_out_a) && $stable(wave_out_b) && $stable(wave_out_c);
   endproperty
   a_stop_hold: assert property (p_stop_hold)
      else $error("pin moved with tick stopped");
endmodule
bind timer16_waveform_mode_control timer16_wave_chk u_chk (.core_clk(core_clk), .rstn(rstn),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_rdata(reg_rdata), .ext_pin(ext_pin), .wave_out_a(wave_out_a), .wave_out_b(wave_out_b),
   .wave_out_c(wave_out_c), .wave_en_a(wave_en_a), .wave_en_b(wave_en_b), .wave_en_c(wave_en_c));

// *** pin_load.sv ***
/* partner: load on one compare pin, seen through the port mux.
   assumes: a pull-down holds the pin low while its driver is off. */
`timescale 1ns/100ps
module pin_load (
   input wire core_clk,
   input wire clr,
   input wire dir_out,
   input wire port_val,
   input wire wave,
   input wire wave_en,
   output reg [15:0] hi_cnt
);
   // waveform owns the pin only while enabled, driver needs the direction bit
   wire pin = dir_out ? (wave_en ? wave : port_val) : 1'b0;
   // high-time counter, cleared by the bench
   always @(posedge core_clk) begin
      if (clr)
         hi_cnt <= 16'h0000;
      else if (pin)
         hi_cnt <= hi_cnt + 16'h0001;
   end
endmodule

// *** tb_timer16_waveform_mode_control.sv ***
/* testbench: register port, waveform duty per mode, tick select rates.
   assumes: design, checker and pin_load compiled before it. */
`timescale 1ns/100ps
module tb_timer16_waveform_mode_control;
   reg core_clk = 1'b0;
   reg rstn = 1'b0;
   reg [3:0] reg_addr = 4'h0;
   reg [15:0] reg_wdata = 16'h0000;
   reg reg_wr = 1'b0;
   reg reg_rd = 1'b0;
   reg ext_pin = 1'b0;
   reg clr = 1'b0;
   reg dir = 1'b1;
   reg rd_q = 1'b0;
   wire [15:0] reg_rdata;
   wire wave_out_a, wave_out_b, wave_out_c, wave_en_a, wave_en_b, wave_en_c;
   wire [15:0] hi_a, hi_b, hi_c;
   logic [16:0] exp_q[$];
   logic [15:0] cap_q[$];
   logic [16:0] e_v;
   logic [15:0] seed = 16'h003e;
   logic [15:0] r, c0, c1;
   int dv[7] = '{2048, 256, 32, 8, 2, 128, 128};
   integer err_count = 0, tests_run = 0, cycles = 0, i;
   timer16_waveform_mode_control u_dut (.core_clk(core_clk), .rstn(rstn), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .ext_pin(ext_pin), .wave_out_a(wave_out_a), .wave_out_b(wave_out_b), .wave_out_c(wave_out_c),
      .wave_en_a(wave_en_a), .wave_en_b(wave_en_b), .wave_en_c(wave_en_c));
   pin_load u_la (.core_clk(core_clk), .clr(clr), .dir_out(dir), .port_val(1'b0),
      .wave(wave_out_a), .wave_en(wave_en_a), .hi_cnt(hi_a));
   pin_load u_lb (.core_clk(core_clk), .clr(clr), .dir_out(dir), .port_val(1'b0),
      .wave(wave_out_b), .wave_en(wave_en_b), .hi_cnt(hi_b));
   pin_load u_lc (.core_clk(core_clk), .clr(clr), .dir_out(dir), .port_val(1'b0),
      .wave(wave_out_c), .wave_en(wave_en_c), .hi_cnt(hi_c));
   initial begin
      forever #2.5 core_clk = ~core_clk;
   end
   // ================
   // helpers
   function automatic logic [15:0] xs();
      seed = seed ^ (seed << 7);
      seed = seed ^ (seed >> 9);
      seed = seed ^ (seed << 8);
      return seed;
   endfunction
   task final_report;
      if (err_count == 0 && tests_run > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task chk_rd(input [15:0] e);
      chk_duty("reg_rdata", e, reg_rdata);
   endtask
   task chk_duty(input string nm, input [15:0] e, input [15:0] g);
      tests_run = tests_run + 1;
      if (g !== e) begin
         err_count = err_count + 1;
         $display("[ERR] %s exp %h got %h", nm, e, g);
      end
   endtask
   // bus tasks set both strobes each edge so accesses run back to back
   task wr(input [3:0] a, input [15:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_rd <= 1'b0;
      reg_wr <= 1'b1;
   endtask
   task rd(input [3:0] a, input [15:0] e, input cap = 1'b0);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wr <= 1'b0;
      reg_rd <= 1'b1;
      exp_q.push_back({cap, e});
   endtask
   task waitc(input integer n);
      @(posedge core_clk);
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      repeat (n) @(posedge core_clk);
   endtask
   // program, settle, then count pin high time over 480 cycles
   task run_cfg(input [7:0] ca, cb, input [15:0] a, b, c, ea, eb, ec, ef);
      wr(4'h1, 16'h0000);
      wr(4'h2, 16'h0000);
      wr(4'h7, 16'h000f);
      wr(4'h3, a);
      wr(4'h4, b);
      wr(4'h5, c);
      wr(4'h0, {8'h00, ca});
      wr(4'h1, {8'h00, cb});
      waitc(60);
      clr <= 1'b1;
      @(posedge core_clk);
      clr <= 1'b0;
      repeat (480) @(posedge core_clk);
      #1;
      chk_duty("pin_a", ea, hi_a);
      chk_duty("pin_b", eb, hi_b);
      chk_duty("pin_c", ec, hi_c);
      rd(4'h7, ef);
   endtask
   // ================
   // monitor: read results against noted expectations, ext pin, timeout
   always @(posedge core_clk) begin
      cycles <= cycles + 1;
      if (rd_q) begin
         e_v = exp_q.pop_front();
         if (e_v[16])
            cap_q.push_back(reg_rdata);
         else
            chk_rd(e_v[15:0]);
      end
      rd_q <= reg_rd;
      if (cycles % 8 == 0)
         ext_pin <= !ext_pin;
      if (cycles > 30000) begin
         err_count = err_count + 1;
         final_report;
      end
   end
   // ================
   // main sequence
   initial begin
      repeat (3) @(posedge core_clk);
      rstn <= 1'b1;
      waitc(8);
      rd(4'h0, 16'h0000);
      rd(4'h1, 16'h0000);
      rd(4'h7, 16'h0000);
      rd(4'h2, 16'h0000);
      rd(4'h2, 16'h0000);
      // random controls with tick stopped; unmapped write must not land
      for (i = 0; i < 12; i = i + 1) begin
         r = xs();
         wr(4'h0, r);
         wr(4'h1, r & 16'h00f8);
         wr({1'b1, r[10:8]}, r);
         rd(4'h0, {8'h00, r[7:0]});
         rd(4'h1, {11'h000, r[4:3], 3'h0});
         rd({1'b1, r[10:8]}, 16'h0000);
         waitc(3);
      end
      run_cfg(8'h6c, 8'h09, 16'h0002, 16'h0001, 16'h0001, 16'h00f0, 16'h0000, 16'h01e0, 16'h000e);
      run_cfg(8'h6f, 8'h19, 16'h0009, 16'h0003, 16'h0003, 16'h00f0, 16'h00c0, 16'h0120, 16'h000f);
      run_cfg(8'h6f, 8'h19, 16'h0009, 16'h0009, 16'h0009, 16'h00f0, 16'h01e0, 16'h0000, 16'h000f);
      run_cfg(8'h6f, 8'h11, 16'h0008, 16'h0003, 16'h0003, 16'h00f0, 16'h00b4, 16'h012c, 16'h000f);
      run_cfg(8'h6d, 8'h11, 16'h0008, 16'h0003, 16'h0003, 16'h00f0, 16'h00b4, 16'h012c, 16'h000f);
      run_cfg(8'hfd, 8'h19, 16'h0008, 16'h0003, 16'h0003, 16'h0000, 16'h0000, 16'h0000, 16'h0000);
      // tick rates: count advance over exactly 2048 cycles per select code
      wr(4'h0, 16'h0000);
      for (i = 1; i < 8; i = i + 1) begin
         wr(4'h1, i[15:0]);
         waitc(16);
         rd(4'h2, 16'h0000, 1'b1);
         waitc(2046);
         rd(4'h2, 16'h0000, 1'b1);
         waitc(2);
         c0 = cap_q.pop_front();
         c1 = cap_q.pop_front();
         chk_duty("tick_count", 16'(dv[i-1]), c1 - c0);
      end
      final_report;
   end
endmodule
